// [sse_pkg.sv]
// constants and types for the skip and subtract execution block
// Overview of operation
// [RULE1] bit-test skip: skip when selected bit is one
// [RULE2] taken skip inserts dummy cycle, two cycles
// [RULE3] zero tested value: no skip, continue
// [RULE4] byte-test skip writes the byte back unchanged
// [RULE5] byte-test skip: skip when byte nonzero
// [RULE6] working register minus memory into working register
// [RULE7] working register minus memory into memory
// [RULE8] working register minus immediate into working register
// [RULE9] carry cleared on borrow, set otherwise
// [RULE10] subtracts update six flags from result
// [RULE11] skips leave all flags unchanged
// [RULE12] nibble exchange swaps memory nibbles, no flags
package sse_pkg;
  // byte offsets of the registers
  localparam logic [9:0] SSE_OFS_CMD = 10'h000;
  localparam logic [9:0] SSE_OFS_WREG = 10'h004;
  localparam logic [9:0] SSE_OFS_STATUS = 10'h008;
  localparam logic [9:0] SSE_OFS_MEM = 10'h100;
  // command register fields
  localparam int SSE_CMD_OP_LSB = 0;
  localparam int SSE_CMD_BIT_LSB = 4;
  localparam int SSE_CMD_IMM_LSB = 8;
  localparam int SSE_CMD_ADR_LSB = 16;
  // status register fields
  localparam int SSE_ST_C = 0;
  localparam int SSE_ST_HALF_BORROW = 1;
  localparam int SSE_ST_Z = 2;
  localparam int SSE_ST_RANGE_EXCEEDED = 3;
  localparam int SSE_ST_SIGNED_ORDER = 4;
  localparam int SSE_ST_MULTI_NULL = 5;
  localparam int SSE_ST_SKIP = 8;
  localparam int SSE_ST_BUSY = 9;
  localparam int SSE_ST_DUMMY = 10;
  // values after reset
  localparam logic [31:0] SSE_RST_CMD = 32'h0000_0000;
  localparam logic [7:0] SSE_RST_WREG = 8'h00;
  localparam logic [5:0] SSE_RST_FLAGS = 6'h00;
  // cycles of a taken skip and of any other command
  localparam int SSE_SKIP_CYCLES = 2;
  localparam int SSE_PLAIN_CYCLES = 1;

  typedef enum logic [2:0] {
    SSE_OP_BIT_SKIP = 3'h0,
    SSE_OP_BYTE_SKIP = 3'h1,
    SSE_OP_SUB_W = 3'h2,
    SSE_OP_SUB_M = 3'h3,
    SSE_OP_SUB_IMM = 3'h4,
    SSE_OP_SWAP = 3'h5
  } sse_op_t;

  typedef enum {
    SSE_IDLE,
    SSE_EXEC,
    SSE_DUMMY
  } sse_state_t;
endpackage

// [sse_core.sv]
// skip and subtract execution core with a wishbone register slave
`timescale 1ns/100ps
module sse_core
  import sse_pkg::*;
#(
  parameter int MEM_DEPTH = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [9:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  output logic o_busy,
  output logic o_skip
);
  localparam int AW = $clog2(MEM_DEPTH);

  initial begin
    if (MEM_DEPTH < 2 || MEM_DEPTH > 64 || (1 << AW) != MEM_DEPTH) begin
      $error("MEM_DEPTH must be a power of two from 2 to 64");
    end
  end

  function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_mem(input logic [9:0] adr);
    return adr >= SSE_OFS_MEM &&
           adr < SSE_OFS_MEM + 10'(4 * MEM_DEPTH) && adr[1:0] == 2'b00;
  endfunction

  logic [7:0] mem_q [MEM_DEPTH];
  logic mem_we;
  logic [AW-1:0] mem_wa;
  logic [7:0] mem_wd;

  sse_state_t state_q, state_d;
  logic [31:0] cmd_q, cmd_d;
  logic [7:0] wreg_q, wreg_d;
  logic [5:0] flags_q, flags_d;
  logic skip_q, skip_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic busy_q, busy_d;

  logic req;
  logic [AW-1:0] bus_ma;
  logic [AW-1:0] ex_ma;
  logic [2:0] ex_bit;
  logic [7:0] ex_imm;
  logic [7:0] ex_m;
  logic [7:0] sub_b;
  logic [8:0] diff;
  logic [4:0] ldiff;
  logic ov;

  assign req = i_wb_cyc && i_wb_stb && !ack_q;
  assign bus_ma = i_wb_adr[AW+1:2];
  assign ex_ma = cmd_q[SSE_CMD_ADR_LSB +: AW];
  assign ex_bit = cmd_q[SSE_CMD_BIT_LSB +: 3];
  assign ex_imm = cmd_q[SSE_CMD_IMM_LSB +: 8];
  assign ex_m = mem_q[ex_ma];

  always_comb begin
    sub_b = ex_m;
    if (sse_op_t'(cmd_q[SSE_CMD_OP_LSB +: 3]) == SSE_OP_SUB_IMM) begin
      sub_b = ex_imm; // see [RULE8]
    end
    diff = {1'b0, wreg_q} - {1'b0, sub_b};
    ldiff = {1'b0, wreg_q[3:0]} - {1'b0, sub_b[3:0]};
    ov = (wreg_q[7] != sub_b[7]) && (diff[7] != wreg_q[7]);
  end

  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    wreg_d = wreg_q;
    flags_d = flags_q;
    skip_d = skip_q;
    busy_d = busy_q;
    ack_d = req;
    rdat_d = 32'h0000_0000;
    mem_we = 1'b0;
    mem_wa = bus_ma;
    mem_wd = i_wb_dat[7:0];
    // bus writes are ignored while a command runs so the
    // core never races the bus on the same byte
    if (req && !i_wb_we) begin
      if (i_wb_adr == SSE_OFS_CMD) begin
        rdat_d = cmd_q;
      end else if (i_wb_adr == SSE_OFS_WREG) begin
        rdat_d = {24'h00_0000, wreg_q};
      end else if (i_wb_adr == SSE_OFS_STATUS) begin
        rdat_d = {21'h00_0000, state_q == SSE_DUMMY, busy_q, skip_q,
                  2'h0, flags_q};
      end else if (is_mem(i_wb_adr)) begin
        rdat_d = {24'h00_0000, mem_q[bus_ma]};
      end
    end
    if (req && i_wb_we && state_q == SSE_IDLE) begin
      if (i_wb_adr == SSE_OFS_CMD) begin
        cmd_d = merge_sel(cmd_q, i_wb_dat, i_wb_sel);
        state_d = SSE_EXEC;
        busy_d = 1'b1;
        skip_d = 1'b0;
      end else if (i_wb_adr == SSE_OFS_WREG && i_wb_sel[0]) begin
        wreg_d = i_wb_dat[7:0];
      end else if (i_wb_adr == SSE_OFS_STATUS && i_wb_sel[0]) begin
        flags_d = i_wb_dat[5:0];
      end else if (is_mem(i_wb_adr) && i_wb_sel[0]) begin
        mem_we = 1'b1;
      end
    end
    case (state_q)
      SSE_IDLE: begin
      end
      SSE_EXEC: begin
        state_d = SSE_IDLE;
        busy_d = 1'b0;
        mem_wa = ex_ma;
        case (sse_op_t'(cmd_q[SSE_CMD_OP_LSB +: 3]))
          SSE_OP_BIT_SKIP: begin
            // flags untouched by both skip forms, see [RULE11]
            if (ex_m[ex_bit]) begin // see [RULE1]
              skip_d = 1'b1;
              state_d = SSE_DUMMY; // see [RULE2]
              busy_d = 1'b1;
            end // else falls through, see [RULE3]
          end
          SSE_OP_BYTE_SKIP: begin
            mem_we = 1'b1;
            mem_wd = ex_m; // see [RULE4]
            if (ex_m != 8'h00) begin // see [RULE5]
              skip_d = 1'b1;
              state_d = SSE_DUMMY; // see [RULE2]
              busy_d = 1'b1;
            end // see [RULE3]
          end
          SSE_OP_SUB_W, SSE_OP_SUB_M, SSE_OP_SUB_IMM: begin
            if (sse_op_t'(cmd_q[SSE_CMD_OP_LSB +: 3]) == SSE_OP_SUB_M)
            begin
              mem_we = 1'b1;
              mem_wd = diff[7:0]; // see [RULE7]
            end else begin
              wreg_d = diff[7:0]; // see [RULE6] see [RULE8]
            end
            flags_d[SSE_ST_C] = !diff[8]; // see [RULE9]
            flags_d[SSE_ST_HALF_BORROW] = !ldiff[4]; // see [RULE10]
            flags_d[SSE_ST_Z] = diff[7:0] == 8'h00; // see [RULE10]
            flags_d[SSE_ST_RANGE_EXCEEDED] = ov; // see [RULE10]
            flags_d[SSE_ST_SIGNED_ORDER] = !(ov ^ diff[7]); // see [RULE10]
            flags_d[SSE_ST_MULTI_NULL] = diff[7:0] == 8'h00; // see [RULE10]
          end
          SSE_OP_SWAP: begin
            mem_we = 1'b1;
            mem_wd = {ex_m[3:0], ex_m[7:4]}; // see [RULE12]
          end
          default: begin
          end
        endcase
      end
      SSE_DUMMY: begin
        // slot of the discarded instruction, see [RULE2]
        state_d = SSE_IDLE;
        busy_d = 1'b0;
      end
      default: begin
        state_d = SSE_IDLE;
        busy_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_q <= SSE_IDLE;
      cmd_q <= SSE_RST_CMD;
      wreg_q <= SSE_RST_WREG;
      flags_q <= SSE_RST_FLAGS;
      skip_q <= 1'b0;
      busy_q <= 1'b0;
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      wreg_q <= wreg_d;
      flags_q <= flags_d;
      skip_q <= skip_d;
      busy_q <= busy_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // memory contents are not reset; software loads them
  always_ff @(posedge i_ref_clk) begin
    if (mem_we) begin
      mem_q[mem_wa] <= mem_wd;
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;
  assign o_busy = busy_q;
  assign o_skip = skip_q;
endmodule // sse_core

// [sse_core_keep.sv]
// no logic here; the whole core lives in sse_core
`timescale 1ns/100ps

// [sse_checker.sv]
// port assertions for the skip and subtract core
`timescale 1ns/100ps
module sse_checker #(
  parameter int MEM_DEPTH = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [9:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic o_wb_ack,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_busy,
  input wire logic o_skip
);
  wire take = i_wb_cyc && i_wb_stb && !o_wb_ack;
  wire cmd_go = take && i_wb_we && i_wb_adr == 10'h000;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  ack_lat_a: assert property (take |=> o_wb_ack)
    else $error("no ack after request");
  ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  cmd_busy_a: assert property (cmd_go && !o_busy |=> o_busy)
    else $error("command did not start");
  busy_cause_a: assert property (
    $rose(o_busy) |-> $past(cmd_go))
    else $error("busy without command");
  skip_two_a: assert property (
    $rose(o_busy) ##1 o_skip |-> o_busy ##1 !o_busy)
    else $error("taken skip not two cycles");
  no_skip_one_a: assert property (
    $rose(o_busy) ##1 !o_skip |-> !o_busy)
    else $error("plain command not one cycle");
  skip_src_a: assert property (
    $changed(o_skip) |-> $past(o_busy) || $past(cmd_go))
    else $error("skip changed without command");
  unmap_rd_a: assert property (o_wb_ack && !$past(i_wb_we) &&
    $past(i_wb_adr) == 10'h00c |-> o_wb_dat == 32'h0)
    else $error("unmapped read not zero");
  cover property ($rose(o_busy) ##1 o_skip);
  cover property ($rose(o_busy) ##1 !o_skip);
  cover property (o_wb_ack && $past(i_wb_adr) == 10'h00c);
endmodule // sse_checker

bind sse_core sse_checker #(.MEM_DEPTH(MEM_DEPTH)) u_sse_checker (
  .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_ack(o_wb_ack),
  .o_wb_dat(o_wb_dat), .o_busy(o_busy), .o_skip(o_skip));

// [tb.sv]
// self-checking bench for the skip and subtract core
`timescale 1ns/100ps
module tb;
  logic i_ref_clk = 0, i_reset = 1, i_wb_cyc = 0, i_wb_stb = 0, i_wb_we = 0;
  logic [9:0] i_wb_adr = 0;
  logic [3:0] i_wb_sel = 0;
  logic [31:0] i_wb_dat = 0, o_wb_dat, exp_q[$];
  logic o_wb_ack, o_busy, o_skip;
  int miscompares = 0, comparisons = 0, cycles = 0;
  integer seed = 32'h26f4b782;
  always #25 i_ref_clk = ~i_ref_clk;
  sse_core #(.MEM_DEPTH(16)) u_sse_core (.i_ref_clk(i_ref_clk),
    .i_reset(i_reset), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
    .i_wb_dat(i_wb_dat), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat),
    .o_busy(o_busy), .o_skip(o_skip));
  task conclude;
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t level %b expected %b", $time, got, exp);
    end
  endtask
  // read results are matched in order against the notes left by rd
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      conclude();
    end
    if (o_wb_ack === 1'b1 && i_wb_we === 1'b0 && exp_q.size() > 0)
      chk(o_wb_dat, exp_q.pop_front());
  end
  task wb(input logic we, input logic [9:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= a;
    i_wb_dat <= d;
    i_wb_sel <= 4'hf;
    @(posedge i_ref_clk);
    while (o_wb_ack !== 1'b1) @(posedge i_ref_clk);
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask
  task rd(input logic [9:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  initial begin
    logic [7:0] w, m, im, opd, r, mx, wx;
    logic [5:0] f, fx;
    logic [3:0] ix;
    logic [2:0] bi, op;
    logic sk, ov;
    repeat (20) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    rd(10'h004, 32'h0);
    rd(10'h008, 32'h0);
    rd(10'h00c, 32'h0);
    for (int k = 0; k < 40; k++) begin
      op = 3'(k % 8);
      w = $random(seed);
      m = (k % 4 == 0) ? 8'h00 : 8'($random(seed));
      im = $random(seed);
      f = $random(seed);
      ix = $random(seed);
      bi = $random(seed);
      opd = (op == 3'h4) ? im : m;
      r = w - opd;
      ov = (w[7] ^ opd[7]) & (r[7] ^ w[7]);
      sk = (op == 3'h0) ? m[bi] : (op == 3'h1) ? (m != 8'h00) : 1'b0;
      mx = (op == 3'h3) ? r : (op == 3'h5) ? {m[3:0], m[7:4]} : m;
      wx = (op == 3'h2 || op == 3'h4) ? r : w;
      fx = (op >= 3'h2 && op <= 3'h4) ?
        {r == 0, ~(ov ^ r[7]), ov, r == 0, w[3:0] >= opd[3:0], w >= opd} : f;
      wb(1'b1, 10'h100 + {ix, 2'b00}, {24'h0, m});
      wb(1'b1, 10'h004, {24'h0, w});
      wb(1'b1, 10'h008, {26'h0, f});
      wb(1'b1, 10'h000, {12'h0, ix, im, 1'b0, bi, 1'b0, op});
      chk_bit(o_busy, 1'b1);
      @(posedge i_ref_clk);
      chk_bit(o_busy, sk);
      rd(10'h008, {23'h0, sk, 2'b00, fx});
      chk_bit(o_skip, sk);
      rd(10'h004, {24'h0, wx});
      rd(10'h100 + {ix, 2'b00}, {24'h0, mx});
    end
    conclude();
  end
endmodule // tb
